// File: rtl/exec_pkg.sv
// Purpose: types for the instruction subset execution block
// Assumes: opcodes are pre-decoded by the fetch stage
// Notes: operand byte arrives with the instruction
package exec_pkg;

   typedef enum logic [4:0] {
      OP_IDLE = 5'h00,
      OP_COMPLEMENT_A = 5'h01,
      OP_DECIMAL_ADJUST = 5'h02,
      OP_DECREMENT_M = 5'h03,
      OP_DECREMENT_A = 5'h04,
      OP_INCREMENT_M = 5'h05,
      OP_INCREMENT_A = 5'h06,
      OP_HALT = 5'h07,
      OP_DIRECT_JUMP = 5'h08,
      OP_MOVE_M_TO_A = 5'h09,
      OP_MOVE_IMM_TO_A = 5'h0A,
      OP_MOVE_A_TO_M = 5'h0B,
      OP_OR_M_TO_A = 5'h0C,
      OP_OR_IMM_TO_A = 5'h0D,
      OP_OR_TO_M = 5'h0E,
      OP_RETURN = 5'h0F,
      OP_RETURN_IMM = 5'h10,
      OP_RETURN_IRQ = 5'h11,
      OP_ROTATE_M = 5'h12,
      OP_ROTATE_A = 5'h13,
      OP_ROTATE_CARRY = 5'h14
   } opcode_e;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_RETURN = 3'b010,
      ST_HALTED = 3'b100
   } state_e;

   typedef struct packed {
      logic timer_condition_two;
      logic timer_condition_one;
      logic watchdog_timeout_flag;
      logic power_down_flag;
      logic overflow_flag;
      logic zero_flag;
      logic aux_carry_flag;
      logic carry_flag;
   } flags_s;

   typedef struct packed {
      logic valid;
      opcode_e op;
      logic [7:0] mem_addr;
      logic [7:0] operand;
      logic [7:0] imm;
      logic [12:0] jump_addr;
   } instr_s;

   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } mem_wr_s;

endpackage : exec_pkg

// File: rtl/exec_subset.sv
// Purpose: executes one subset of an 8-bit core's instruction set
// Assumes: operand byte of [m] is presented with the instruction
// Notes: registers reached over AXI4-Lite
// Function
// [RL1] complement of data byte goes to accumulator, zero updated, byte kept
// [RL2] low nibble over 9 or aux carry: add 6, nibble carry = not aux carry
// [RL3] high nibble plus nibble carry over 9 or carry: add 6, carry set
// [RL4] decimal adjust result goes to memory, only carry may change
// [RL5] in-place decrement and increment modulo 256, only zero changes
// [RL6] decrement and increment to accumulator keep source, only zero changes
// [RL7] halt stops execution, gates system clock, pc advances, state kept
// [RL8] halt clears watchdog and prescaler, sets power-down, clears time-out
// [RL9] direct jump replaces pc bits 0..12 with address field, no flags
// [RL10] move from memory or immediate into accumulator, no flag change
// [RL11] move accumulator to memory without flag change
// [RL12] idle op only advances pc by one
// [RL13] or with memory or immediate into accumulator, only zero changes
// [RL14] or to memory writes result back to byte, only zero changes
// [RL15] return pops stack into pc over two cycles, flags kept
// [RL16] return with literal pops pc and loads immediate into accumulator
// [RL17] interrupt return pops pc and sets global interrupt enable bit 0
// [RL18] rotate left in place, bit 7 into bit 0, no flags
// [RL19] rotate left into accumulator, memory and flags kept
// [RL20] rotate through carry: old carry to bit 0, old bit 7 to carry
// [RL21] all but return and halt finish in one cycle, one write
// [RL22] flags not listed as affected keep their values
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "exec_subset_defs.svh"

module exec_subset (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // instruction issue
   input wire exec_pkg::instr_s instr,
   output logic instr_ready,
   // return stack
   input wire logic [`PC_W-1:0] stack_top,
   output logic stack_pop,
   // data memory write
   output exec_pkg::mem_wr_s mem_wr,
   // core control
   input wire logic wake,
   output logic [`PC_W-1:0] pc,
   output logic clock_stop,
   output logic watchdog_clear,
   output logic global_irq_enable,
   output logic [7:0] accumulator,
   output exec_pkg::flags_s flags
);

   exec_pkg::state_e state_reg;
   exec_pkg::opcode_e ret_op_reg;
   logic [7:0] ret_imm_reg;
   logic [`PC_W-1:0] ret_target_reg;
   logic run_reg;
   logic issue;
   logic [7:0] m;
   logic [7:0] acc_next;
   exec_pkg::flags_s flags_next;
   exec_pkg::mem_wr_s wr_next;
   logic [`PC_W-1:0] pc_next;
   logic [4:0] lo_sum;
   logic [4:0] hi_sum;
   logic lo_fix;
   logic hi_fix;
   logic nibble_carry_internal;
   logic [7:0] bcd_result;
   logic wr_commit;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic w_lane0_q;
   logic wake_req;
   logic ret_done;

   assign m = instr.operand;
   assign issue = instr.valid && instr_ready;
   assign wr_commit = !awready && !wready && !bvalid;
   assign wake_req = wake ||
      (wr_commit && aw_addr_q == `REG_CTRL && w_lane0_q &&
       w_data_q[`CTRL_WAKE_BIT]);
   assign ret_done = (state_reg == exec_pkg::ST_RETURN);

   // decimal adjust, both nibbles
   always_comb
   begin
      lo_fix = ({1'b0, accumulator[3:0]} > `BCD_LIMIT) ||
         flags.aux_carry_flag; // RL2
      lo_sum = lo_fix ? {1'b0, accumulator[3:0]} + `BCD_ADJUST
                      : {1'b0, accumulator[3:0]};
      nibble_carry_internal = lo_fix ? !flags.aux_carry_flag : 1'b0; // RL2
      hi_sum = {1'b0, accumulator[7:4]} + {4'h0, nibble_carry_internal};
      hi_fix = (hi_sum > `BCD_LIMIT) || flags.carry_flag; // RL3
      if (hi_fix)
      begin
         hi_sum = hi_sum + `BCD_ADJUST; // RL3
      end
      bcd_result = {hi_sum[3:0], lo_sum[3:0]};
   end

   // one-cycle execution: next accumulator, flags, memory write, pc
   always_comb
   begin
      acc_next = accumulator;
      flags_next = flags; // RL22
      wr_next = '0;
      wr_next.addr = instr.mem_addr;
      pc_next = pc + `PC_W'(1); // RL12
      case (instr.op)
         exec_pkg::OP_COMPLEMENT_A:
         begin
            acc_next = ~m; // RL1
            flags_next.zero_flag = (~m == 8'h00);
         end
         exec_pkg::OP_DECIMAL_ADJUST:
         begin
            wr_next.en = 1'b1; // RL4
            wr_next.data = bcd_result;
            flags_next.carry_flag = hi_fix ? 1'b1 : flags.carry_flag; // RL3
         end
         exec_pkg::OP_DECREMENT_M, exec_pkg::OP_INCREMENT_M:
         begin
            wr_next.en = 1'b1;
            wr_next.data = (instr.op == exec_pkg::OP_INCREMENT_M) ?
               m + 8'h01 : m - 8'h01; // RL5
            flags_next.zero_flag = (wr_next.data == 8'h00);
         end
         exec_pkg::OP_DECREMENT_A, exec_pkg::OP_INCREMENT_A:
         begin
            acc_next = (instr.op == exec_pkg::OP_INCREMENT_A) ?
               m + 8'h01 : m - 8'h01; // RL6
            flags_next.zero_flag = (acc_next == 8'h00);
         end
         exec_pkg::OP_HALT:
         begin
            flags_next.power_down_flag = 1'b1; // RL8
            flags_next.watchdog_timeout_flag = 1'b0;
         end
         exec_pkg::OP_DIRECT_JUMP:
         begin
            pc_next = {pc[`PC_W-1:`JUMP_W], instr.jump_addr}; // RL9
         end
         exec_pkg::OP_MOVE_M_TO_A: acc_next = m; // RL10
         exec_pkg::OP_MOVE_IMM_TO_A: acc_next = instr.imm; // RL10
         exec_pkg::OP_MOVE_A_TO_M:
         begin
            wr_next.en = 1'b1; // RL11
            wr_next.data = accumulator;
         end
         exec_pkg::OP_OR_M_TO_A, exec_pkg::OP_OR_IMM_TO_A:
         begin
            acc_next = accumulator | ((instr.op == exec_pkg::OP_OR_M_TO_A) ?
               m : instr.imm); // RL13
            flags_next.zero_flag = (acc_next == 8'h00);
         end
         exec_pkg::OP_OR_TO_M:
         begin
            wr_next.en = 1'b1; // RL14
            wr_next.data = accumulator | m;
            flags_next.zero_flag = (wr_next.data == 8'h00);
         end
         exec_pkg::OP_ROTATE_M:
         begin
            wr_next.en = 1'b1; // RL18
            wr_next.data = {m[6:0], m[7]};
         end
         exec_pkg::OP_ROTATE_A: acc_next = {m[6:0], m[7]}; // RL19
         exec_pkg::OP_ROTATE_CARRY:
         begin
            wr_next.en = 1'b1; // RL20
            wr_next.data = {m[6:0], flags.carry_flag};
            flags_next.carry_flag = m[7];
         end
         default:
         begin
            acc_next = accumulator;
         end
      endcase
   end

   // sequencer: run, two-cycle return, halt
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= exec_pkg::ST_RUN;
         instr_ready <= 1'b0;
         clock_stop <= 1'b0;
         ret_op_reg <= exec_pkg::OP_IDLE;
         ret_imm_reg <= 8'h00;
         ret_target_reg <= `PC_RESET;
      end
      else
      begin
         case (state_reg)
            exec_pkg::ST_RUN:
            begin
               instr_ready <= run_reg;
               if (issue && (instr.op == exec_pkg::OP_RETURN ||
                   instr.op == exec_pkg::OP_RETURN_IMM ||
                   instr.op == exec_pkg::OP_RETURN_IRQ))
               begin
                  state_reg <= exec_pkg::ST_RETURN; // RL15
                  instr_ready <= 1'b0;
                  ret_op_reg <= instr.op;
                  ret_imm_reg <= instr.imm;
                  ret_target_reg <= stack_top;
               end
               else if (issue && instr.op == exec_pkg::OP_HALT)
               begin
                  state_reg <= exec_pkg::ST_HALTED; // RL7
                  instr_ready <= 1'b0;
                  clock_stop <= 1'b1;
               end
            end
            exec_pkg::ST_RETURN:
            begin
               state_reg <= exec_pkg::ST_RUN;
               instr_ready <= run_reg;
            end
            exec_pkg::ST_HALTED:
            begin
               if (wake_req)
               begin
                  state_reg <= exec_pkg::ST_RUN;
                  clock_stop <= 1'b0;
               end
            end
            default:
            begin
               state_reg <= exec_pkg::ST_RUN;
               instr_ready <= 1'b0;
               clock_stop <= 1'b0;
            end
         endcase
      end
   end

   // architectural state written once at the end of the cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         accumulator <= `ACCUM_RESET;
         flags <= `FLAGS_RESET;
         pc <= `PC_RESET;
         mem_wr <= '0;
         stack_pop <= 1'b0;
         watchdog_clear <= 1'b0;
      end
      else
      begin
         mem_wr <= '0;
         stack_pop <= 1'b0;
         watchdog_clear <= 1'b0;
         if (ret_done)
         begin
            pc <= ret_target_reg; // RL15
            stack_pop <= 1'b1;
            if (ret_op_reg == exec_pkg::OP_RETURN_IMM)
            begin
               accumulator <= ret_imm_reg; // RL16
            end
         end
         else if (issue)
         begin
            accumulator <= acc_next; // RL21
            flags <= flags_next;
            mem_wr <= wr_next;
            watchdog_clear <= (instr.op == exec_pkg::OP_HALT); // RL8
            if (instr.op != exec_pkg::OP_RETURN &&
                instr.op != exec_pkg::OP_RETURN_IMM &&
                instr.op != exec_pkg::OP_RETURN_IRQ)
            begin
               pc <= pc_next;
            end
         end
      end
   end

   // global interrupt enable: hardware set wins over software clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         global_irq_enable <= 1'b0;
      end
      else if (ret_done && ret_op_reg == exec_pkg::OP_RETURN_IRQ)
      begin
         global_irq_enable <= 1'b1; // RL17
      end
      else if (wr_commit && aw_addr_q == `REG_INTERRUPT_CONTROL_REG && w_lane0_q)
      begin
         global_irq_enable <= w_data_q[`INTERRUPT_CONTROL_REG_GIE_BIT];
      end
   end

   // control register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run_reg <= `CTRL_RUN_RESET;
      end
      else if (wr_commit && aw_addr_q == `REG_CTRL && w_lane0_q)
      begin
         run_reg <= w_data_q[`CTRL_RUN_BIT];
      end
   end

   // axi write: address and data taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_lane0_q <= 1'b0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awready <= 1'b0;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready)
         begin
            wready <= 1'b0;
            w_data_q <= wdata;
            w_lane0_q <= wstrb[0];
         end
         if (wr_commit)
         begin
            bvalid <= 1'b1;
            bresp <= (aw_addr_q == `REG_CTRL || aw_addr_q == `REG_STATUS ||
               aw_addr_q == `REG_ACCUM || aw_addr_q == `REG_PC ||
               aw_addr_q == `REG_INTERRUPT_CONTROL_REG) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // axi read
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= `RESP_OKAY;
         case (araddr)
            `REG_CTRL: rdata <= {31'h0000_0000, run_reg};
            `REG_STATUS: rdata <= {24'h00_0000, flags};
            `REG_ACCUM: rdata <= {24'h00_0000, accumulator};
            `REG_PC: rdata <= {18'h0_0000, pc};
            `REG_INTERRUPT_CONTROL_REG: rdata <= {31'h0000_0000, global_irq_enable};
            default:
            begin
               rdata <= 32'h0000_0000;
               rresp <= `RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_ret_taken;
      issue && (instr.op == exec_pkg::OP_RETURN ||
         instr.op == exec_pkg::OP_RETURN_IMM ||
         instr.op == exec_pkg::OP_RETURN_IRQ);
   endsequence
   sequence s_ret_second;
      !instr_ready ##1 stack_pop;
   endsequence

   property p_complement;
      issue && instr.op == exec_pkg::OP_COMPLEMENT_A |=>
         accumulator == ~$past(instr.operand) && !mem_wr.en &&
         flags.zero_flag == ($past(instr.operand) == 8'hFF);
   endproperty
   a_complement: assert property (p_complement) // RL1
      else $error("complement result wrong");

   property p_bcd_carry;
      issue && instr.op == exec_pkg::OP_DECIMAL_ADJUST |=>
         mem_wr.en && mem_wr.data == $past(bcd_result) &&
         flags[7:1] == $past(flags[7:1]) &&
         flags.carry_flag == ($past(hi_fix) || $past(flags.carry_flag));
   endproperty
   a_bcd_carry: assert property (p_bcd_carry) // RL4
      else $error("decimal adjust write or carry wrong");

   property p_bcd_low;
      issue && instr.op == exec_pkg::OP_DECIMAL_ADJUST &&
         (accumulator[3:0] > 4'h9 || flags.aux_carry_flag) |=>
         mem_wr.data[3:0] == $past(accumulator[3:0]) + 4'h6;
   endproperty
   a_bcd_low: assert property (p_bcd_low) // RL2
      else $error("low nibble adjust wrong");

   property p_increment_m;
      issue && instr.op == exec_pkg::OP_INCREMENT_M |=>
         mem_wr.en && mem_wr.data == $past(instr.operand) + 8'h01 &&
         flags.carry_flag == $past(flags.carry_flag);
   endproperty
   a_increment_m: assert property (p_increment_m) // RL5
      else $error("increment in place wrong");

   property p_halt;
      issue && instr.op == exec_pkg::OP_HALT |=>
         clock_stop && watchdog_clear && flags.power_down_flag &&
         !flags.watchdog_timeout_flag && pc == $past(pc) + 14'h0001 &&
         !instr_ready;
   endproperty
   a_halt: assert property (p_halt) // RL8
      else $error("halt effects missing");

   property p_jump;
      issue && instr.op == exec_pkg::OP_DIRECT_JUMP |=>
         pc[12:0] == $past(instr.jump_addr) && flags == $past(flags) &&
         pc[13] == $past(pc[13]);
   endproperty
   a_jump: assert property (p_jump) // RL9
      else $error("jump target wrong");

   property p_return;
      s_ret_taken |=> s_ret_second ##0 pc == $past(stack_top, 2) &&
         flags == $past(flags, 2);
   endproperty
   a_return: assert property (p_return) // RL15
      else $error("return not two cycles");

   property p_interrupt_return_op;
      issue && instr.op == exec_pkg::OP_RETURN_IRQ |-> ##2 global_irq_enable;
   endproperty
   a_interrupt_return_op: assert property (p_interrupt_return_op) // RL17
      else $error("interrupt enable not set");

   property p_rotate_carry;
      issue && instr.op == exec_pkg::OP_ROTATE_CARRY |=>
         mem_wr.data == {$past(instr.operand[6:0]), $past(flags.carry_flag)}
         && flags.carry_flag == $past(instr.operand[7]) &&
         flags.zero_flag == $past(flags.zero_flag);
   endproperty
   a_rotate_carry: assert property (p_rotate_carry) // RL20
      else $error("rotate through carry wrong");

   property p_idle;
      issue && instr.op == exec_pkg::OP_IDLE |=>
         pc == $past(pc) + 14'h0001 && !mem_wr.en &&
         accumulator == $past(accumulator) && flags == $past(flags);
   endproperty
   a_idle: assert property (p_idle) // RL12
      else $error("idle op changed state");

endmodule : exec_subset

// File: rtl/exec_subset_defs.svh
// Purpose: constants for the instruction subset execution block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: definitions only
`ifndef EXEC_SUBSET_DEFS_SVH
`define EXEC_SUBSET_DEFS_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ACCUM 8'h08
`define REG_PC 8'h0C
`define REG_INTERRUPT_CONTROL_REG 8'h10

// control register fields and reset value
`define CTRL_RUN_BIT 0
`define CTRL_WAKE_BIT 1
`define CTRL_RUN_RESET 1'b1

// interrupt control register: global enable bit
`define INTERRUPT_CONTROL_REG_GIE_BIT 0

// reset values
`define FLAGS_RESET 8'h00
`define ACCUM_RESET 8'h00
`define PC_RESET 14'h0000

// decimal adjust figures
`define BCD_LIMIT 5'h09
`define BCD_ADJUST 5'h06

// widths
`define PC_W 14
`define JUMP_W 13

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: verification/core_side_model.sv
// Purpose: return stack and data memory across the core side of the block
// Assumes: the bench pushes return addresses; the block pops them
// Notes: an empty stack shows a toggling pattern, never a held value
`timescale 1ns/10ps

module core_side_model (
   // clock
   input wire logic aclk,
   // data memory writes from the block
   input wire exec_pkg::mem_wr_s mem_wr,
   // return stack
   input wire logic stack_pop,
   output logic [13:0] stack_top
);
   logic [7:0] mem [0:255];
   logic [13:0] stack [0:7];
   logic [13:0] noise = 14'h2A5A;
   int depth = 0;

   // called away from the rising edge so it cannot race a pop
   task automatic push(input logic [13:0] v);
      stack[depth] = v;
      depth++;
   endtask : push

   always @(posedge aclk)
   begin
      noise <= ~noise;
      if (mem_wr.en === 1'b1) mem[mem_wr.addr] <= mem_wr.data;
      if (stack_pop === 1'b1 && depth > 0) depth <= depth - 1;
   end

   assign stack_top = depth > 0 ? stack[depth - 1] : noise;
endmodule : core_side_model

// File: verification/test_mcu_instruction_exec_subset.sv
// Purpose: self-checking bench for the instruction subset block
// Assumes: the bench tracks each [m] and hands it over with the op
// Notes: drivers queue expected results, watchers compare them
`timescale 1ns/10ps
`include "exec_subset_defs.svh"

module test_mcu_instruction_exec_subset;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, wake = 1'b0;
   exec_pkg::instr_s instr = '0;
   logic awready, wready, bvalid, arready, rvalid, instr_ready, stack_pop;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [13:0] stack_top, pc;
   exec_pkg::mem_wr_s mem_wr;
   logic clock_stop, watchdog_clear, global_irq_enable, tk;
   logic [7:0] accumulator;
   exec_pkg::flags_s flags;
   // bench's own view of the core state
   logic [7:0] acc = 8'h00;
   exec_pkg::flags_s f = '0;
   logic [13:0] epc = 14'h0;
   logic gie = 1'b0;
   logic [7:0] em [0:15];
   logic [30:0] st_q [$];
   logic [16:0] mw_q [$];
   logic [33:0] bus_q [$];
   logic [1:0] due = 2'b00;
   int seed, num_errors = 0, checked = 0;

   always #12.5 aclk = ~aclk;

   exec_subset exec_subset_inst (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .instr(instr),
      .instr_ready(instr_ready), .stack_top(stack_top),
      .stack_pop(stack_pop), .mem_wr(mem_wr), .wake(wake), .pc(pc),
      .clock_stop(clock_stop), .watchdog_clear(watchdog_clear),
      .global_irq_enable(global_irq_enable), .accumulator(accumulator),
      .flags(flags)
   );

   core_side_model core_side_model_inst (
      .aclk(aclk), .mem_wr(mem_wr), .stack_pop(stack_pop),
      .stack_top(stack_top)
   );

   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize

   task automatic check(input logic [33:0] s, input logic [33:0] e);
      checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask : check

   function automatic logic isret(input exec_pkg::opcode_e o);
      return o inside {exec_pkg::OP_RETURN, exec_pkg::OP_RETURN_IMM,
         exec_pkg::OP_RETURN_IRQ};
   endfunction : isret

   task automatic axw(input logic [7:0] ad, input logic [31:0] d,
      input logic [1:0] e);
      bus_q.push_back({e, 32'h0});
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
   endtask : axw

   task automatic axr(input logic [7:0] ad, input logic [33:0] e);
      bus_q.push_back(e);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
   endtask : axr

   task automatic run(input exec_pkg::opcode_e op);
      logic [3:0] a;
      logic [7:0] m, x, r;
      logic [13:0] t;
      logic [4:0] lo, hi;
      logic nc, dc, w;
      int n;
      a = 4'($random(seed));
      x = 8'($random(seed));
      t = 14'($random(seed));
      m = em[a];
      lo = {1'b0, acc[3:0]};
      nc = lo > 5'h09 || f.aux_carry_flag;
      lo = nc ? lo + 5'h06 : lo;
      nc = nc && !f.aux_carry_flag;
      hi = {1'b0, acc[7:4]} + {4'h0, nc};
      dc = hi > 5'h09 || f.carry_flag;
      hi = dc ? hi + 5'h06 : hi;
      w = 1'b1;
      case (op)
         exec_pkg::OP_DECIMAL_ADJUST: r = {hi[3:0], lo[3:0]};
         exec_pkg::OP_DECREMENT_M: r = m - 8'h01;
         exec_pkg::OP_INCREMENT_M: r = m + 8'h01;
         exec_pkg::OP_MOVE_A_TO_M: r = acc;
         exec_pkg::OP_OR_TO_M: r = acc | m;
         exec_pkg::OP_ROTATE_M: r = {m[6:0], m[7]};
         exec_pkg::OP_ROTATE_CARRY: r = {m[6:0], f.carry_flag};
         default: w = 1'b0;
      endcase
      case (op)
         exec_pkg::OP_COMPLEMENT_A: acc = ~m;
         exec_pkg::OP_DECREMENT_A: acc = m - 8'h01;
         exec_pkg::OP_INCREMENT_A: acc = m + 8'h01;
         exec_pkg::OP_MOVE_M_TO_A: acc = m;
         exec_pkg::OP_MOVE_IMM_TO_A, exec_pkg::OP_RETURN_IMM: acc = x;
         exec_pkg::OP_OR_M_TO_A: acc = acc | m;
         exec_pkg::OP_OR_IMM_TO_A: acc = acc | x;
         exec_pkg::OP_ROTATE_A: acc = {m[6:0], m[7]};
         default: ;
      endcase
      case (op)
         exec_pkg::OP_COMPLEMENT_A, exec_pkg::OP_DECREMENT_A,
         exec_pkg::OP_INCREMENT_A, exec_pkg::OP_OR_M_TO_A,
         exec_pkg::OP_OR_IMM_TO_A: f.zero_flag = acc == 8'h00;
         exec_pkg::OP_DECREMENT_M, exec_pkg::OP_INCREMENT_M,
         exec_pkg::OP_OR_TO_M: f.zero_flag = r == 8'h00;
         exec_pkg::OP_HALT:
            {f.watchdog_timeout_flag, f.power_down_flag} = 2'b01;
         exec_pkg::OP_ROTATE_CARRY: f.carry_flag = m[7];
         exec_pkg::OP_DECIMAL_ADJUST: f.carry_flag = f.carry_flag | dc;
         default: ;
      endcase
      if (op == exec_pkg::OP_DIRECT_JUMP) epc = {epc[13], t[12:0]};
      else if (isret(op)) epc = t;
      else epc = epc + 14'h0001;
      if (op == exec_pkg::OP_RETURN_IRQ) gie = 1'b1;
      st_q.push_back({epc, acc, f, gie});
      if (w) mw_q.push_back({1'b1, 4'h0, a, r});
      if (w) em[a] = r;
      // a pending pop must land before the new return address goes on
      if (isret(op))
      begin
         instr.valid <= 1'b0;
         repeat (3) @(negedge aclk);
         core_side_model_inst.push(t);
         @(posedge aclk);
      end
      instr <= '{1'b1, op, {4'h0, a}, m, x, t[12:0]};
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (instr_ready !== 1'b1 && n < 40);
      check(instr_ready, 1'b1);
      if (op == exec_pkg::OP_HALT)
      begin
         instr.valid <= 1'b0;
         @(negedge aclk);
         check({clock_stop, instr_ready}, 2'b10);
         check(watchdog_clear, 1'b1);
         @(posedge aclk);
         if (x[0]) axw(`REG_CTRL, 32'h3, `RESP_OKAY);
         else
         begin
            wake <= 1'b1;
            @(posedge aclk);
            wake <= 1'b0;
         end
      end
   endtask : run

   always @(posedge aclk)
   begin
      tk = instr.valid && instr_ready === 1'b1 && aresetn;
      if (due[0])
         check({pc, accumulator, flags, global_irq_enable},
            st_q.pop_front());
      due <= {tk && isret(instr.op), (tk && !isret(instr.op)) || due[1]};
      if (mem_wr.en === 1'b1)
         check(mem_wr, mw_q.size() > 0 ? mw_q.pop_front() : 17'h0);
      if ((rvalid && rready) === 1'b1)
         check({rresp, rdata}, bus_q.pop_front());
      if ((bvalid && bready) === 1'b1)
         check({bresp, 32'h0}, bus_q.pop_front());
   end

   initial
   begin
      seed = 32'h4EDF;
      for (int i = 0; i < 16; i++)
      begin
         em[i] = 8'($random(seed));
         core_side_model_inst.mem[i] = em[i];
      end
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(`REG_CTRL, 34'h1);
      axw(`REG_STATUS, 32'hFF, `RESP_OKAY);
      axr(`REG_STATUS, 34'h0);
      axw(8'h14, 32'h1, `RESP_SLVERR);
      axr(8'h14, {`RESP_SLVERR, 32'h0});
      for (int k = 0; k < 21; k++) run(exec_pkg::opcode_e'(k));
      repeat (300) run(exec_pkg::opcode_e'($unsigned($random(seed)) % 21));
      instr.valid <= 1'b0;
      axw(`REG_INTERRUPT_CONTROL_REG, 32'h0, `RESP_OKAY);
      gie = 1'b0;
      axr(`REG_INTERRUPT_CONTROL_REG, 34'h0);
      axr(`REG_STATUS, {26'h0, f});
      axr(`REG_ACCUM, {26'h0, acc});
      axr(`REG_PC, {20'h0, epc});
      // issue is blocked while the run bit is low
      axw(`REG_CTRL, 32'h0, `RESP_OKAY);
      repeat (2) @(negedge aclk);
      check(instr_ready, 1'b0);
      @(posedge aclk);
      axw(`REG_CTRL, 32'h1, `RESP_OKAY);
      for (int i = 0; i < 16; i++)
         check(core_side_model_inst.mem[i], em[i]);
      check(34'(st_q.size() + mw_q.size() + core_side_model_inst.depth),
         34'h0);
      summarize();
   end

   // a hung handshake ends the run here
   initial
   begin
      #750000;
      num_errors++;
      summarize();
   end
endmodule : test_mcu_instruction_exec_subset
